// ### verilog/mrs_pkg.sv
package mrs_pkg;

  // Widths
  localparam int DW = 8;
  localparam int PW = 16;

  // Program memory map
  localparam logic [15:0] PM_LAST     = 16'h1FFF;
  localparam logic [15:0] VEC_ADDR_HI = 16'h0000;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0001;
  localparam logic [15:0] RESET_ADDR  = 16'h0100;

  // Register file map
  localparam logic [7:0] GP_LAST            = 8'hB7;
  localparam logic [7:0] COMMON_BASE        = 8'hC0;
  localparam logic [7:0] COMMON_LAST        = 8'hCF;
  localparam logic [7:0] PAGE1_LAST         = 8'h13;
  localparam logic [7:0] STACK_POINTER_ADDR = 8'hD9;
  localparam logic [7:0] STACK_POINTER_RST  = 8'h00;

  // Physical storage layout
  localparam logic [7:0] IDX_COMMON = 8'hB8;
  localparam logic [7:0] IDX_PAGE1  = 8'hC8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH, ST_POP, ST_POP_WAIT, ST_VEC0, ST_VEC1, ST_VEC2, ST_RD_WAIT
  } mrs_state_t;

  typedef enum logic [2:0] {
    OP_DATA_PUSH, OP_CALL, OP_INTR, OP_DATA_POP, OP_SUB_RETURN, OP_INT_RETURN
  } mrs_op_t;

  typedef enum logic [1:0] {RD_BYTE, RD_PAIR, RD_STACK_PTR, RD_NONE} mrs_rd_t;

  // Index of the last byte of a stack sequence
  function automatic logic [1:0] op_last(input mrs_op_t op);
    case (op)
      OP_CALL, OP_SUB_RETURN: op_last = 2'h1;
      OP_INTR, OP_INT_RETURN: op_last = 2'h2;
      default:                op_last = 2'h0;
    endcase
  endfunction : op_last

  // Register address to storage index, bit 8 marks a mapped location
  function automatic logic [8:0] reg_index(input logic [7:0] a, input logic pg);
    logic [7:0] s;
    s = 8'h00;
    reg_index = 9'h000;
    if (a >= COMMON_BASE && a <= COMMON_LAST)
    begin
      s = IDX_COMMON + {4'h0, a[3:0]};
      reg_index = {1'b1, s};
    end
    else if (!pg && a <= GP_LAST)
      reg_index = {1'b1, a};
    else if (pg && a <= PAGE1_LAST)
    begin
      s = IDX_PAGE1 + a;
      reg_index = {1'b1, s};
    end
  endfunction : reg_index

endpackage : mrs_pkg

// ### verilog/mrs_ram.sv
`timescale 1ns/1ps
module mrs_ram (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Access port
  input  wire logic                   we,
  input  wire logic [6:0]             addr,
  input  wire logic [mrs_pkg::DW-1:0] wdata,
  output      logic [mrs_pkg::DW-1:0] rdata
);
  import mrs_pkg::*;

  logic [DW-1:0] mem [128];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else
      rdata <= mem[addr];
  end

endmodule : mrs_ram

// ### verilog/mrs_stack_ptr.sv
`timescale 1ns/1ps
module mrs_stack_ptr (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Commands, at most one a cycle
  input  wire logic                   dec,
  input  wire logic                   inc,
  input  wire logic                   load,
  input  wire logic [mrs_pkg::DW-1:0] load_val,
  // Current value
  output      logic [mrs_pkg::DW-1:0] stack_pointer
);
  import mrs_pkg::*;

  typedef struct packed {
    logic [DW-1:0] value;
  } mrs_sp_regs_t;

  mrs_sp_regs_t r_q;
  mrs_sp_regs_t r_d;

  always_comb
  begin
    r_d = r_q;
    if (load)
      r_d.value = load_val;
    else if (dec)
      r_d.value = r_q.value - 8'h01; // RULE17
    else if (inc)
      r_d.value = r_q.value + 8'h01; // RULE17
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      r_q <= '{value: STACK_POINTER_RST};
    else
      r_q <= r_d;
  end

  assign stack_pointer = r_q.value;

  a_sp_wrap_down: assert property (@(posedge clk) disable iff (!resetn) // RULE17
    (dec && !load && stack_pointer == 8'h00) |=> stack_pointer == 8'hFF)
    else $error("stack pointer did not wrap to FF");

endmodule : mrs_stack_ptr

// ### verilog/mrs_regfile_stack.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Program space is 8 KB, addresses 0 to 1FFF on a 16-bit bus.
// RULE2: Interrupt vector address is read from program bytes 0000 and 0001.
// RULE3: Fetching starts at program address 0100 after reset.
// RULE4: Register traffic uses its own 8-bit bus, apart from program memory.
// RULE5: Register file gives 184 general bytes; 56 are for control functions.
// RULE6: Addresses 00 to B7 are general storage; the upper 72 are control and working.
// RULE7: Page 1 holds 20 bytes of display memory, also usable as storage.
// RULE8: Common area C0 to CF is reachable from any selected page.
// RULE9: Software reaches the common area only by 4-bit working register numbers.
// RULE10: Register pairs start even; high byte even, low byte in next odd.
// RULE11: Call pushes the program counter; subroutine return pops it back.
// RULE12: Interrupt pushes program counter and flags; interrupt return restores both.
// RULE13: Push decrements then writes; pop reads then increments.
// RULE14: Stack pointer always addresses the most recently pushed byte.
// RULE15: Stack pointer is the 8-bit register at D9, undefined after reset; the code resets it to 00.
// RULE16: Software should load the stack pointer within 00 to B7.
// RULE17: Stack pointer wraps modulo 256, so 00 decrements to FF.
// RULE18: Program counter is pushed low byte first, popped high byte first.
module mrs_regfile_stack (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Register bus
  input  wire logic                   rb_rd,
  input  wire logic                   rb_wr,
  input  wire logic [mrs_pkg::DW-1:0] rb_addr,
  input  wire logic                   rb_page,
  input  wire logic                   rb_work,
  input  wire logic                   rb_pair,
  input  wire logic [mrs_pkg::PW-1:0] rb_wdata,
  output      logic                   rb_ready,
  output      logic [mrs_pkg::PW-1:0] rb_rdata,
  output      logic                   rb_rvalid,
  output      logic                   rb_bad_mode,
  // Stack requests
  input  wire logic                   push_req,
  input  wire logic [mrs_pkg::DW-1:0] push_data,
  input  wire logic                   pop_req,
  input  wire logic                   call_req,
  input  wire logic [mrs_pkg::PW-1:0] call_target,
  input  wire logic                   subroutine_return_instr,
  input  wire logic                   int_req,
  input  wire logic [mrs_pkg::DW-1:0] flags_in,
  input  wire logic                   interrupt_return_instr,
  output      logic [mrs_pkg::DW-1:0] pop_data,
  output      logic                   pop_valid,
  output      logic [mrs_pkg::DW-1:0] flags_out,
  output      logic                   flags_valid,
  output      logic [mrs_pkg::DW-1:0] stack_pointer,
  output      logic                   op_done,
  // Program memory
  input  wire logic                   fetch_next,
  input  wire logic                   jump_req,
  input  wire logic [mrs_pkg::PW-1:0] jump_target,
  input  wire logic [mrs_pkg::DW-1:0] pm_rdata,
  output      logic [mrs_pkg::PW-1:0] pm_addr,
  output      logic                   pm_rd
);
  import mrs_pkg::*;

  typedef struct packed {
    mrs_state_t    st;
    mrs_op_t       op;
    logic [1:0]    step;
    logic [PW-1:0] program_counter;
    logic [PW-1:0] target;
    logic [DW-1:0] push_byte;
    logic [DW-1:0] flags;
    logic [DW-1:0] vec_hi;
    mrs_rd_t       rd_kind;
    logic          rd_bank;
    logic [PW-1:0] rd_data;
    logic          rd_valid;
    logic          bad_mode;
    logic [DW-1:0] pop_data;
    logic          pop_valid;
    logic [DW-1:0] flags_out;
    logic          flags_valid;
    logic [PW-1:0] pm_addr;
    logic          pm_rd;
    logic          done;
    logic          ready;
    logic          up;
  } mrs_regs_t;

  mrs_regs_t r_q;
  mrs_regs_t r_d;

  logic [1:0]          bank_we;
  logic [1:0][6:0]     bank_addr;
  logic [1:0][DW-1:0]  bank_wdata;
  logic [1:0][DW-1:0]  bank_rdata;
  logic                sp_dec;
  logic                sp_inc;
  logic                sp_load;
  logic                stack_req;
  logic                acc;
  logic                bad;
  logic [DW-1:0]       eff_addr;
  logic [8:0]          rb_idx;
  logic [8:0]          stk_idx;
  logic [DW-1:0]       stk_addr;
  logic [DW-1:0]       stk_byte;
  logic [DW-1:0]       pop_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage: even and odd banks so a pair moves in one cycle

  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    mrs_ram u_ram (
      .clk    (clk),
      .resetn (resetn),
      .we     (bank_we[b]),
      .addr   (bank_addr[b]),
      .wdata  (bank_wdata[b]),
      .rdata  (bank_rdata[b])
    );
  end

  mrs_stack_ptr u_sp (
    .clk           (clk),
    .resetn        (resetn),
    .dec           (sp_dec),
    .inc           (sp_inc),
    .load          (sp_load),
    .load_val      (rb_wdata[7:0]),
    .stack_pointer (stack_pointer)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  assign stack_req = int_req | call_req | subroutine_return_instr
                   | interrupt_return_instr | push_req | pop_req;
  assign acc       = (r_q.st == ST_IDLE) && !stack_req && (rb_rd || rb_wr); // RULE4
  // Working register n sits at C0 plus n on every page
  assign eff_addr  = rb_work ? (COMMON_BASE | {4'h0, rb_addr[3:0]}) : rb_addr; // RULE8
  assign rb_idx    = reg_index(eff_addr, rb_page); // RULE5 RULE6 RULE7
  // Direct address into common area, odd pair start, or pair off storage
  assign bad       = (!rb_work && rb_addr >= COMMON_BASE && rb_addr <= COMMON_LAST) // RULE9
                   || (rb_pair && (eff_addr[0] || !rb_idx[8])); // RULE10
  assign stk_addr  = (r_q.st == ST_PUSH) ? stack_pointer - 8'h01 : stack_pointer; // RULE13
  assign stk_idx   = reg_index(stk_addr, 1'b0);
  assign pop_byte  = bank_rdata[r_q.rd_bank];

  // Byte of a push sequence: low half of counter first
  always_comb
  begin
    stk_byte = r_q.push_byte;
    if (r_q.op == OP_CALL || r_q.op == OP_INTR)
    begin
      case (r_q.step)
        2'h0:    stk_byte = r_q.program_counter[7:0]; // RULE18
        2'h1:    stk_byte = r_q.program_counter[15:8]; // RULE18
        default: stk_byte = r_q.flags; // RULE12
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    r_d             = r_q;
    r_d.up          = 1'b1;
    r_d.done        = 1'b0;
    r_d.rd_valid    = 1'b0;
    r_d.bad_mode    = 1'b0;
    r_d.pop_valid   = 1'b0;
    r_d.flags_valid = 1'b0;
    r_d.pm_rd       = 1'b0;
    bank_we         = 2'b00;
    bank_addr       = {2{rb_idx[7:1]}};
    bank_wdata      = {2{rb_wdata[7:0]}};
    sp_dec          = 1'b0;
    sp_inc          = 1'b0;
    sp_load         = 1'b0;
    case (r_q.st)
      ST_IDLE:
      begin
        r_d.step = 2'h0;
        if (int_req)
        begin
          r_d.op    = OP_INTR;
          r_d.flags = flags_in;
          r_d.st    = ST_PUSH;
        end
        else if (call_req)
        begin
          r_d.op     = OP_CALL;
          r_d.target = call_target;
          r_d.st     = ST_PUSH;
        end
        else if (subroutine_return_instr)
        begin
          r_d.op = OP_SUB_RETURN;
          r_d.st = ST_POP;
        end
        else if (interrupt_return_instr)
        begin
          r_d.op = OP_INT_RETURN;
          r_d.st = ST_POP;
        end
        else if (push_req)
        begin
          r_d.op        = OP_DATA_PUSH;
          r_d.push_byte = push_data;
          r_d.st        = ST_PUSH;
        end
        else if (pop_req)
        begin
          r_d.op = OP_DATA_POP;
          r_d.st = ST_POP;
        end
        else
        begin
          if (jump_req)
            r_d.program_counter = jump_target & PM_LAST; // RULE1
          else if (fetch_next)
            r_d.program_counter = (r_q.program_counter + 16'h0001) & PM_LAST; // RULE1
          if (acc && bad)
          begin
            r_d.bad_mode = 1'b1;
            r_d.rd_valid = rb_rd;
            r_d.rd_data  = 16'h0000;
            r_d.done     = 1'b1;
          end
          else if (rb_wr)
          begin
            r_d.done = 1'b1;
            if (rb_pair)
            begin
              bank_we    = 2'b11;
              bank_wdata = {rb_wdata[7:0], rb_wdata[15:8]}; // RULE10
            end
            else if (rb_idx[8])
              bank_we[rb_idx[0]] = 1'b1;
            else if (eff_addr == STACK_POINTER_ADDR)
              sp_load = 1'b1; // RULE15
          end
          else if (rb_rd)
          begin
            r_d.st      = ST_RD_WAIT;
            r_d.rd_bank = rb_idx[0];
            if (rb_pair)
              r_d.rd_kind = RD_PAIR;
            else if (rb_idx[8])
              r_d.rd_kind = RD_BYTE;
            else if (eff_addr == STACK_POINTER_ADDR)
              r_d.rd_kind = RD_STACK_PTR; // RULE15
            else
              r_d.rd_kind = RD_NONE;
          end
        end
      end
      ST_RD_WAIT:
      begin
        case (r_q.rd_kind)
          RD_BYTE:      r_d.rd_data = {8'h00, bank_rdata[r_q.rd_bank]};
          RD_PAIR:      r_d.rd_data = {bank_rdata[0], bank_rdata[1]}; // RULE10
          RD_STACK_PTR: r_d.rd_data = {8'h00, stack_pointer};
          default:      r_d.rd_data = 16'h0000;
        endcase
        r_d.rd_valid = 1'b1;
        r_d.done     = 1'b1;
        r_d.st       = ST_IDLE;
      end
      ST_PUSH:
      begin
        // Decrement and write at the new top in the same cycle
        sp_dec                   = 1'b1; // RULE13 RULE14
        bank_addr[stk_idx[0]]    = stk_idx[7:1];
        bank_wdata[stk_idx[0]]   = stk_byte;
        bank_we[stk_idx[0]]      = stk_idx[8]; // RULE11 RULE12
        r_d.step                 = r_q.step + 2'h1;
        if (r_q.step == op_last(r_q.op))
        begin
          if (r_q.op == OP_INTR)
          begin
            r_d.pm_addr = VEC_ADDR_HI; // RULE2
            r_d.pm_rd   = 1'b1;
            r_d.st      = ST_VEC0;
          end
          else
          begin
            if (r_q.op == OP_CALL)
              r_d.program_counter = r_q.target & PM_LAST; // RULE1
            r_d.done = 1'b1;
            r_d.st   = ST_IDLE;
          end
        end
      end
      ST_POP:
      begin
        // Read the current top, then move up
        bank_addr[stk_idx[0]] = stk_idx[7:1];
        r_d.rd_bank           = stk_idx[0];
        sp_inc                = 1'b1; // RULE13
        r_d.st                = ST_POP_WAIT;
      end
      ST_POP_WAIT:
      begin
        r_d.step = r_q.step + 2'h1;
        r_d.st   = ST_POP;
        if (r_q.op == OP_DATA_POP)
          r_d.pop_data = pop_byte;
        else if (r_q.op == OP_INT_RETURN && r_q.step == 2'h0)
          r_d.flags_out = pop_byte; // RULE12
        else if (r_q.step == op_last(r_q.op))
          r_d.program_counter[7:0] = pop_byte; // RULE11 RULE18
        else
          r_d.program_counter[15:8] = pop_byte & PM_LAST[15:8]; // RULE18
        if (r_q.step == op_last(r_q.op))
        begin
          r_d.pop_valid   = (r_q.op == OP_DATA_POP);
          r_d.flags_valid = (r_q.op == OP_INT_RETURN);
          r_d.done        = 1'b1;
          r_d.st          = ST_IDLE;
        end
      end
      ST_VEC0:
      begin
        r_d.pm_addr = VEC_ADDR_LO; // RULE2
        r_d.pm_rd   = 1'b1;
        r_d.st      = ST_VEC1;
      end
      ST_VEC1:
      begin
        r_d.vec_hi = pm_rdata;
        r_d.st     = ST_VEC2;
      end
      ST_VEC2:
      begin
        r_d.program_counter = {r_q.vec_hi, pm_rdata} & PM_LAST; // RULE1 RULE2
        r_d.done            = 1'b1;
        r_d.st              = ST_IDLE;
      end
      default: r_d.st = ST_IDLE;
    endcase
    if (r_d.st != ST_VEC0 && r_d.st != ST_VEC1)
      r_d.pm_addr = r_d.program_counter;
    r_d.ready = (r_d.st == ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_q                 <= '0;
      r_q.st              <= ST_IDLE;
      r_q.program_counter <= RESET_ADDR; // RULE3
      r_q.pm_addr         <= RESET_ADDR; // RULE3
      r_q.ready           <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  assign rb_ready    = r_q.ready;
  assign rb_rdata    = r_q.rd_data;
  assign rb_rvalid   = r_q.rd_valid;
  assign rb_bad_mode = r_q.bad_mode;
  assign pop_data    = r_q.pop_data;
  assign pop_valid   = r_q.pop_valid;
  assign flags_out   = r_q.flags_out;
  assign flags_valid = r_q.flags_valid;
  assign op_done     = r_q.done;
  assign pm_addr     = r_q.pm_addr;
  assign pm_rd       = r_q.pm_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_call_start;
    r_q.st == ST_IDLE && int_req == 1'b0 && call_req;
  endsequence

  sequence s_int_start;
    r_q.st == ST_IDLE && int_req;
  endsequence

  a_reset_fetch_addr: assert property (!r_q.up |-> pm_addr == RESET_ADDR) // RULE3
    else $error("first fetch address is not the reset address");

  a_pm_addr_range: assert property (pm_addr <= PM_LAST) // RULE1
    else $error("program address beyond 8 KB");

  a_call_push_order: assert property (s_call_start |=> // RULE18
    (bank_we != 2'b00 && stk_byte == $past(r_q.program_counter[7:0]))
    ##1 (bank_we != 2'b00 && stk_byte == $past(r_q.program_counter[15:8], 2)))
    else $error("call did not push low then high byte");

  a_push_pre_dec: assert property ((r_q.st == ST_PUSH) |-> // RULE13
    stk_addr == 8'(stack_pointer - 8'h01) ##1 stack_pointer == $past(stk_addr))
    else $error("push did not decrement before writing");

  a_pop_post_inc: assert property ((r_q.st == ST_POP) |-> // RULE14
    stk_addr == stack_pointer ##1 stack_pointer == 8'($past(stack_pointer) + 8'h01))
    else $error("pop did not read then increment");

  a_int_vector_fetch: assert property (s_int_start |-> // RULE2
    ##4 (pm_addr == VEC_ADDR_HI && pm_rd) ##1 (pm_addr == VEC_ADDR_LO && pm_rd))
    else $error("interrupt vector not fetched from 0000 and 0001");

  a_common_map: assert property ((acc && rb_wr && rb_work && !rb_pair) |-> // RULE8
    bank_we[rb_addr[0]]
    && bank_addr[rb_addr[0]] == 7'((IDX_COMMON + {4'h0, rb_addr[3:0]}) >> 1))
    else $error("working register not mapped to common area");

  a_pair_high_even: assert property ((acc && rb_wr && rb_pair && !bad) |-> // RULE10
    bank_we == 2'b11 && bank_wdata[0] == rb_wdata[15:8])
    else $error("pair high byte not written to even register");

  a_sp_reg_read: assert property ((acc && rb_rd && !rb_work && !rb_pair // RULE15
    && rb_addr == STACK_POINTER_ADDR) |-> ##2 (rb_rvalid
    && rb_rdata == {8'h00, $past(stack_pointer, 2)}))
    else $error("stack pointer register read wrong");

  a_gp_decode: assert property ((acc && rb_wr && !rb_pair && !rb_work && !rb_page // RULE6
    && rb_addr <= GP_LAST) |-> bank_we != 2'b00)
    else $error("general register address not decoded as storage");

endmodule : mrs_regfile_stack

// ### verification/mrs_rom_model.sv
`timescale 1ns/1ps
module mrs_rom_model (
  // Clock
  input  wire logic        clk,
  // Program memory side
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  output      logic [7:0]  pm_rdata
);
  import mrs_pkg::*;
  parameter logic [7:0] VEC_HI = 8'h02;
  parameter logic [7:0] VEC_LO = 8'h34;
  // Byte one cycle after the address; inverted garbage when not read
  always @(posedge clk)
  begin
    if (!pm_rd)
      pm_rdata <= ~pm_addr[7:0];
    else if (pm_addr == VEC_ADDR_HI)
      pm_rdata <= VEC_HI;
    else if (pm_addr == VEC_ADDR_LO)
      pm_rdata <= VEC_LO;
    else
      pm_rdata <= pm_addr[7:0];
  end
endmodule : mrs_rom_model

// ### verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import mrs_pkg::*;
  logic clk, resetn, rb_rd, rb_wr, rb_page, rb_work, rb_pair, rb_ready, rb_rvalid;
  logic rb_bad_mode, push_req, pop_req, call_req, subroutine_return_instr, int_req;
  logic interrupt_return_instr, pop_valid, flags_valid, op_done, fetch_next, jump_req;
  logic pm_rd;
  logic [7:0]  rb_addr, push_data, flags_in, pop_data, flags_out, stack_pointer, pm_rdata;
  logic [15:0] rb_wdata, rb_rdata, call_target, jump_target, pm_addr, d;
  logic        bad;
  logic        rv;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  mrs_regfile_stack dut_u (.clk, .resetn, .rb_rd, .rb_wr, .rb_addr, .rb_page, .rb_work,
    .rb_pair, .rb_wdata, .rb_ready, .rb_rdata, .rb_rvalid, .rb_bad_mode, .push_req,
    .push_data, .pop_req, .call_req, .call_target, .subroutine_return_instr, .int_req,
    .flags_in, .interrupt_return_instr, .pop_data, .pop_valid, .flags_out, .flags_valid,
    .stack_pointer, .op_done, .fetch_next, .jump_req, .jump_target, .pm_rdata, .pm_addr,
    .pm_rd);
  mrs_rom_model rom_u (.clk, .pm_addr, .pm_rd, .pm_rdata);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Drop requests at the taking edge, then wait for completion
  task automatic fin();
    int i;
    @(posedge clk);
    {rb_rd, rb_wr, push_req, pop_req, call_req, int_req} <= 6'h00;
    {subroutine_return_instr, interrupt_return_instr, jump_req, fetch_next} <= 4'h0;
    // Write and refusal answers come at the taking edge, reads one edge later
    for (i = 0; i < 20; i++)
    begin
      #1;
      if (op_done === 1'b1)
        break;
      @(posedge clk);
    end
    if (i == 20)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : fin

  task automatic acc(input logic w, input logic [7:0] a, input logic pg, input logic wk,
                     input logic pr, input logic [15:0] wd);
    @(posedge clk);
    rb_wr <= w;
    rb_rd <= !w;
    rb_addr <= a;
    rb_page <= pg;
    rb_work <= wk;
    rb_pair <= pr;
    rb_wdata <= wd;
    fin();
    d = rb_rdata;
    bad = rb_bad_mode;
    rv = rb_rvalid;
  endtask : acc

  task automatic pc_op(input logic j, input logic [15:0] t);
    @(posedge clk);
    jump_req <= j;
    fetch_next <= !j;
    jump_target <= t;
    @(posedge clk);
    jump_req <= 1'b0;
    fetch_next <= 1'b0;
    #1;
  endtask : pc_op

  task automatic t_regs();
    acc(1, 8'h00, 0, 0, 0, 16'h0011);
    acc(1, 8'hB7, 0, 0, 0, 16'h0022);
    acc(1, 8'h13, 1, 0, 0, 16'h0033);
    acc(1, 8'h13, 0, 0, 0, 16'h0044);
    acc(0, 8'h00, 0, 0, 0, 16'h0000); `CHK(d, 16'h0011)
    `CHK(rv, 1'b1)
    `CHK(rb_ready, 1'b1)
    acc(0, 8'hB7, 0, 0, 0, 16'h0000); `CHK(d, 16'h0022)
    acc(0, 8'h13, 1, 0, 0, 16'h0000); `CHK(d, 16'h0033)
    acc(0, 8'h13, 0, 0, 0, 16'h0000); `CHK(d, 16'h0044)
    acc(0, 8'hBA, 0, 0, 0, 16'h0000); `CHK(d, 16'h0000)
    acc(1, 8'h02, 0, 1, 0, 16'h0055);
    acc(0, 8'h02, 1, 1, 0, 16'h0000); `CHK(d, 16'h0055)
    `CHK(bad, 1'b0)
    acc(0, 8'hC2, 0, 0, 0, 16'h0000); `CHK(bad, 1'b1)
    acc(1, 8'h10, 0, 0, 1, 16'hA1B2);
    acc(0, 8'h10, 0, 0, 0, 16'h0000); `CHK(d, 16'h00A1)
    acc(0, 8'h11, 0, 0, 0, 16'h0000); `CHK(d, 16'h00B2)
    acc(0, 8'h10, 0, 0, 1, 16'h0000); `CHK(d, 16'hA1B2)
    acc(0, 8'h11, 0, 0, 1, 16'h0000); `CHK(bad, 1'b1)
  endtask : t_regs

  task automatic t_push_pop();
    acc(1, STACK_POINTER_ADDR, 0, 0, 0, 16'h00B8);
    `CHK(stack_pointer, 8'hB8)
    @(posedge clk);
    push_req <= 1'b1;
    push_data <= 8'h3C;
    fin();
    `CHK(stack_pointer, 8'hB7)
    acc(0, 8'hB7, 0, 0, 0, 16'h0000); `CHK(d, 16'h003C)
    @(posedge clk);
    pop_req <= 1'b1;
    fin();
    `CHK(pop_data, 8'h3C)
    `CHK(pop_valid, 1'b1)
    `CHK(stack_pointer, 8'hB8)
  endtask : t_push_pop

  task automatic t_call_int();
    pc_op(1, 16'h0345);
    `CHK(pm_addr, 16'h0345)
    @(posedge clk);
    call_req <= 1'b1;
    call_target <= 16'h0ABC;
    fin();
    `CHK(pm_addr, 16'h0ABC)
    `CHK(stack_pointer, 8'hB6)
    acc(0, 8'hB7, 0, 0, 0, 16'h0000); `CHK(d, 16'h0045)
    acc(0, 8'hB6, 0, 0, 1, 16'h0000); `CHK(d, 16'h0345)
    @(posedge clk);
    subroutine_return_instr <= 1'b1;
    fin();
    `CHK(pm_addr, 16'h0345)
    `CHK(stack_pointer, 8'hB8)
    @(posedge clk);
    int_req <= 1'b1;
    flags_in <= 8'h5A;
    fin();
    `CHK(pm_addr, 16'h0234)
    `CHK(stack_pointer, 8'hB5)
    acc(0, 8'hB5, 0, 0, 0, 16'h0000); `CHK(d, 16'h005A)
    @(posedge clk);
    interrupt_return_instr <= 1'b1;
    fin();
    `CHK(flags_out, 8'h5A)
    `CHK(flags_valid, 1'b1)
    `CHK(pm_addr, 16'h0345)
    `CHK(stack_pointer, 8'hB8)
  endtask : t_call_int

  task automatic t_wrap();
    acc(1, STACK_POINTER_ADDR, 0, 0, 0, 16'h0000);
    @(posedge clk);
    push_req <= 1'b1;
    push_data <= 8'h77;
    fin();
    acc(0, STACK_POINTER_ADDR, 0, 0, 0, 16'h0000); `CHK(d, 16'h00FF)
    @(posedge clk);
    pop_req <= 1'b1;
    fin();
    `CHK(stack_pointer, 8'h00)
    pc_op(1, 16'h3FFF);
    `CHK(pm_addr, PM_LAST)
    pc_op(0, 16'h0000);
    `CHK(pm_addr, 16'h0000)
  endtask : t_wrap

  initial
  begin
    resetn = 1'b0;
    {rb_rd, rb_wr, rb_page, rb_work, rb_pair, push_req, pop_req, call_req} = 8'h00;
    {subroutine_return_instr, int_req, interrupt_return_instr, fetch_next} = 4'h0;
    jump_req = 1'b0;
    rb_addr = 8'h00;
    push_data = 8'h00;
    flags_in = 8'h00;
    rb_wdata = 16'h0000;
    call_target = 16'h0000;
    jump_target = 16'h0000;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(pm_addr, RESET_ADDR)
    `CHK(stack_pointer, STACK_POINTER_RST)
    t_regs();
    t_push_pop();
    t_call_int();
    t_wrap();
    wrap_up();
  end
endmodule : tb
